// *** zcd_regs.svh ***
// register offsets, field positions and reset values for the crossing block
// assumes inclusion from the package and the design modules only
`ifndef ZCD_REGS_SVH
`define ZCD_REGS_SVH

`define ADDR_W            4
`define OFF_CONTROL       4'h0
`define OFF_STATUS        4'h1
`define OFF_MASK          4'h2
`define OFF_PERIPH        4'h3
`define CTL_ENABLE_BIT    7
`define CTL_LEVEL_BIT     5
`define CTL_INVERT_BIT    4
`define CTL_RISE_BIT      1
`define CTL_FALL_BIT      0
`define CTL_WR_MASK       8'h93
`define CTL_RESET         8'h00
`define IRQ_CROSS_BIT     0
`define IRQ_ENABLE_BIT    0
`define IRQ_ALL_MASK      8'h03
`define MASK_RESET        8'h00
`define STAT_RESET        8'h00
`define PERIPH_RESET      8'h00
`define PERIPH_WR_MASK    8'h03
`define PERIPH_GLOBAL_BIT 1
`define PERIPH_PERIPH_BIT 0
`define SYNC_STAGES       2

`endif

// *** zcd_pkg.sv ***
// types shared by the crossing block
// assumes zcd_regs.svh is on the include path
`include "zcd_regs.svh"
package zcd_pkg;
  typedef logic [7:0]              reg_byte_t;
  typedef logic [`ADDR_W-1:0]      reg_addr_t;
  typedef enum logic [1:0] {
    RST_HOLD,
    RST_LOAD,
    RUN
  } boot_e;
endpackage : zcd_pkg

// *** zcd_sync.sv ***
// two-flop synchroniser for the asynchronous comparator level
// assumes the input comes from the analog front end, outside clk_i's domain
`timescale 1ns/1ns
module zcd_sync
#(
  parameter int STAGES = 2
)
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic async_i,
  output logic      sync_o
);
  logic [STAGES-1:0] chain_ff;
  logic [STAGES-1:0] nxt_chain;

  always_comb
  begin
    nxt_chain = {chain_ff[STAGES-2:0], async_i};
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      chain_ff <= '0;
    else
      chain_ff <= nxt_chain;
  end

  assign sync_o = chain_ff[STAGES-1];
endmodule : zcd_sync

// *** zcd_logic.sv ***
// digital side of the zero-crossing detector: control, status, interrupt
// assumes the comparator level is asynchronous; fuse is a static strap
`timescale 1ns/1ns
// Functional notes
// - front end sinks above reference, sources below; raw level follows that
// - invert off: status reads 1 while sinking, 0 while sourcing
// - invert on: status inverted, edges detected on inverted level
// - rising and falling edge detectors on the adjusted level
// - flag sets when an enabled detector fires; stays until software clears
// - rise enable gates rising detector only, fall enable falling only
// - changing invert can produce an edge regardless of module enable
// - a set in the same cycle as a clear wins
// - enable 1 takes over the pin; 0 returns it to normal control
// - fuse clear: enabled after reset; fuse set: software enables
// - current action and flag logic keep running in sleep
module zcd_logic
  import zcd_pkg::*;
(
  input  wire logic      clk_i,
  input  wire logic      rst_i,
  input  wire reg_addr_t addr_i,
  input  wire reg_byte_t wdata_i,
  input  wire logic      wr_i,
  input  wire logic      rd_i,
  output reg_byte_t      rdata_o,
  input  wire logic      sink_active_i,
  input  wire logic      fuse_disable_i,
  output logic           pin_override_o,
  output logic           crossing_level_o,
  output logic           irq_o
);
  logic      sync_level;
  boot_e     boot_ff,    nxt_boot;
  reg_byte_t ctl_ff,     nxt_ctl;
  reg_byte_t stat_ff,    nxt_stat;
  reg_byte_t mask_ff,    nxt_mask;
  reg_byte_t periph_ff,  nxt_periph;
  reg_byte_t rdata_ff,   nxt_rdata;
  logic      level_ff,   nxt_level;
  logic      prev_ff,    nxt_prev;
  logic      irq_ff,     nxt_irq;
  logic      rise_evt,   fall_evt, cross_evt;

  function automatic logic hit(input reg_addr_t a, input reg_addr_t off);
    hit = (a == off);
  endfunction : hit

  // comparator level only ever seen through the synchroniser
  zcd_sync #(.STAGES(`SYNC_STAGES)) u_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .async_i (sink_active_i),
    .sync_o  (sync_level)
  );

  // polarity applies combinationally, so an invert write makes an edge
  // without depending on the module enable or any clock gating
  always_comb
  begin
    nxt_level = sync_level ^ ctl_ff[`CTL_INVERT_BIT];
    nxt_prev  = level_ff;
    rise_evt  = level_ff & ~prev_ff;
    fall_evt  = ~level_ff & prev_ff;
    cross_evt = (rise_evt & ctl_ff[`CTL_RISE_BIT]) |
                (fall_evt & ctl_ff[`CTL_FALL_BIT]);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      level_ff <= 1'b0;
      prev_ff  <= 1'b0;
    end
    else
    begin
      level_ff <= nxt_level;
      prev_ff  <= nxt_prev;
    end
  end

  // fuse sampled one cycle after reset release, never under reset
  always_comb
  begin
    nxt_boot = boot_ff;
    nxt_ctl  = ctl_ff;
    case (boot_ff)
      RST_HOLD: nxt_boot = RST_LOAD;
      RST_LOAD:
      begin
        nxt_boot = RUN;
        nxt_ctl[`CTL_ENABLE_BIT] = ~fuse_disable_i;
        if (wr_i && hit(addr_i, `OFF_CONTROL))
          nxt_ctl = wdata_i & `CTL_WR_MASK;
      end
      RUN:
      begin
        if (wr_i && hit(addr_i, `OFF_CONTROL))
          nxt_ctl = wdata_i & `CTL_WR_MASK;
      end
      default: nxt_boot = RUN;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      boot_ff <= RST_HOLD;
      ctl_ff  <= `CTL_RESET;
    end
    else
    begin
      boot_ff <= nxt_boot;
      ctl_ff  <= nxt_ctl;
    end
  end

  // nothing here depends on a sleep signal, so sleep leaves it running
  always_comb
  begin
    nxt_stat = stat_ff;
    if (wr_i && hit(addr_i, `OFF_STATUS))
      nxt_stat = stat_ff & ~wdata_i & `IRQ_ALL_MASK;
    if (cross_evt)
      nxt_stat[`IRQ_CROSS_BIT] = 1'b1;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      stat_ff <= `STAT_RESET;
    else
      stat_ff <= nxt_stat;
  end

  // enables are plain storage; only the interrupt path and the bus read use them
  always_comb
  begin
    nxt_mask = mask_ff;
    if (wr_i && hit(addr_i, `OFF_MASK))
      nxt_mask = wdata_i & `IRQ_ALL_MASK;
    nxt_periph = periph_ff;
    if (wr_i && hit(addr_i, `OFF_PERIPH))
      nxt_periph = wdata_i & `PERIPH_WR_MASK;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mask_ff   <= `MASK_RESET;
      periph_ff <= `PERIPH_RESET;
    end
    else
    begin
      mask_ff   <= nxt_mask;
      periph_ff <= nxt_periph;
    end
  end

  // registered so the interrupt line never glitches on an enable write
  always_comb
  begin
    // crossing enable, peripheral and global enables all required
    nxt_irq = stat_ff[`IRQ_CROSS_BIT] & mask_ff[`IRQ_ENABLE_BIT] &
              periph_ff[`PERIPH_PERIPH_BIT] &
              periph_ff[`PERIPH_GLOBAL_BIT];
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      irq_ff <= 1'b0;
    else
      irq_ff <= nxt_irq;
  end

  always_comb
  begin
    nxt_rdata = 8'h00;
    if (rd_i)
    begin
      case (addr_i)
        `OFF_CONTROL:
        begin
          nxt_rdata = ctl_ff;
          nxt_rdata[`CTL_LEVEL_BIT] = level_ff;
        end
        `OFF_STATUS: nxt_rdata = stat_ff;
        `OFF_MASK:   nxt_rdata = mask_ff;
        `OFF_PERIPH: nxt_rdata = periph_ff;
        default:     nxt_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      rdata_ff <= 8'h00;
    else
      rdata_ff <= nxt_rdata;
  end

  assign rdata_o          = rdata_ff;
  assign pin_override_o   = ctl_ff[`CTL_ENABLE_BIT];
  assign crossing_level_o = level_ff;
  assign irq_o            = irq_ff;

  chk_flag_on_rise: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (rise_evt && ctl_ff[`CTL_RISE_BIT]) |=> stat_ff[`IRQ_CROSS_BIT])
    else $error("rising edge did not set flag");

  chk_flag_on_fall: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (fall_evt && ctl_ff[`CTL_FALL_BIT]) |=> stat_ff[`IRQ_CROSS_BIT])
    else $error("falling edge did not set flag");

  chk_rise_gated: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (!stat_ff[`IRQ_CROSS_BIT] && rise_evt && !ctl_ff[`CTL_RISE_BIT] &&
     !fall_evt) |=> !stat_ff[`IRQ_CROSS_BIT])
    else $error("disabled rising edge set flag");

  chk_set_wins: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (cross_evt && wr_i && hit(addr_i, `OFF_STATUS)) |=>
      stat_ff[`IRQ_CROSS_BIT])
    else $error("clear beat a simultaneous set");

  chk_flag_sticky: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (stat_ff[`IRQ_CROSS_BIT] && !(wr_i && hit(addr_i, `OFF_STATUS)))
      |=> stat_ff[`IRQ_CROSS_BIT])
    else $error("flag cleared without software");

  chk_level_polarity: assert property (
    @(posedge clk_i) disable iff (rst_i)
    $stable(ctl_ff[`CTL_INVERT_BIT]) |=>
      (level_ff == ($past(sync_level) ^ $past(ctl_ff[`CTL_INVERT_BIT]))))
    else $error("status level polarity wrong");

  chk_sync_delay: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (!$past(rst_i) && !$past(rst_i, 2)) |->
      (sync_level == $past(sink_active_i, 2)))
    else $error("synchroniser depth wrong");

  chk_fuse_boot: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (boot_ff == RST_LOAD && !wr_i) |=>
      (pin_override_o == !$past(fuse_disable_i)))
    else $error("enable not loaded from fuse");

  chk_invert_edge: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ($stable(sync_level)[*3] && $changed(ctl_ff[`CTL_INVERT_BIT]))
      |=> (rise_evt || fall_evt))
    else $error("invert change gave no edge");

  chk_fall_gated: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (!stat_ff[`IRQ_CROSS_BIT] && fall_evt && !ctl_ff[`CTL_FALL_BIT] &&
     !rise_evt) |=> !stat_ff[`IRQ_CROSS_BIT])
    else $error("disabled falling edge set flag");

  chk_flag_clear: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (wr_i && hit(addr_i, `OFF_STATUS) && wdata_i[`IRQ_CROSS_BIT] &&
     !cross_evt) |=> !stat_ff[`IRQ_CROSS_BIT])
    else $error("write of one did not clear flag");

  chk_irq_raise: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (stat_ff[`IRQ_CROSS_BIT] && mask_ff[`IRQ_ENABLE_BIT] &&
     periph_ff[`PERIPH_PERIPH_BIT] && periph_ff[`PERIPH_GLOBAL_BIT])
      |=> irq_o)
    else $error("enabled flag raised no interrupt");

  chk_irq_quiet: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (!stat_ff[`IRQ_CROSS_BIT] || !mask_ff[`IRQ_ENABLE_BIT]) |=> !irq_o)
    else $error("interrupt without enabled flag");

  chk_rdata_idle: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !rd_i |=> (rdata_o == 8'h00))
    else $error("read data outside read cycle");

  chk_ctl_read: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (rd_i && hit(addr_i, `OFF_CONTROL)) |=>
      ((rdata_o & ~`CTL_WR_MASK) == {2'b00, $past(level_ff), 5'h00}))
    else $error("control read level or spare bits wrong");

  chk_ctl_write: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (boot_ff == RUN && wr_i && hit(addr_i, `OFF_CONTROL)) |=>
      (pin_override_o == $past(wdata_i[`CTL_ENABLE_BIT])))
    else $error("enable write did not reach pin control");
endmodule : zcd_logic

// *** crossing_front_end.sv ***
// analog front end model: sinks above the reference, sources below
// assumes the bench sets the pin level; output is asynchronous to clk_i
`timescale 1ns/1ns
module crossing_front_end
(
  input  wire logic above_ref_i,
  output logic      sink_active_o
);
  // a small lag keeps the level change off the clock edge
  // a continuous assignment also settles the level 3 ns after time zero
  assign #3 sink_active_o = above_ref_i;
endmodule : crossing_front_end

// *** tb.sv ***
// self-checking bench for the crossing block: bus, edges, flag, interrupt
// assumes the offsets and bit layout of zcd_regs.svh
`timescale 1ns/1ns
module tb
  import zcd_pkg::*;
;
  logic      clk_i, rst_i, wr_i, rd_i, fuse_i, above, sink, rd_seen;
  logic      pin_ovr, level, irq;
  reg_addr_t addr_i;
  reg_byte_t wdata_i, rdata_o, exp_q[$];
  int        mismatches, checked;
  logic [31:0] seed;
  zcd_logic u_zcd_logic (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .sink_active_i(sink), .fuse_disable_i(fuse_i),
    .pin_override_o(pin_ovr), .crossing_level_o(level), .irq_o(irq));
  crossing_front_end u_crossing_front_end (.above_ref_i(above),
    .sink_active_o(sink));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  task automatic check(input string n, input reg_byte_t s, input reg_byte_t e);
    checked++;
    if (s !== e)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : check
  task automatic wr(input reg_addr_t a, input reg_byte_t d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i    <= 1'b0;
  endtask : wr
  task automatic rd(input reg_addr_t a, input reg_byte_t e);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk_i);
    rd_i   <= 1'b0;
    @(negedge clk_i);
  endtask : rd
  task automatic settle();
    // input change reaches irq_o within five edges; margin for the lag
    repeat (8) @(posedge clk_i);
    @(negedge clk_i);
  endtask : settle
  task automatic end_sim();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // read data stand only in the cycle after the strobe
  always @(posedge clk_i) rd_seen <= rd_i;
  always @(negedge clk_i)
    if (rd_seen === 1'b1)
      check("rdata", rdata_o, exp_q.pop_front());
  initial
  begin
    repeat (5000) @(posedge clk_i);
    mismatches++;
    end_sim();
  end
  initial
  begin
    {wr_i, rd_i, fuse_i, above, addr_i, wdata_i} = '0;
    rst_i = 1'b1;
    seed  = 32'd82577;
    mismatches = 0;
    checked = 0;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    rd(`OFF_CONTROL, 8'h80);
    check("pin_override", {7'h0, pin_ovr}, 8'h01);
    rd(4'h5, 8'h00);
    above <= 1'b1;
    settle();
    rd(`OFF_CONTROL, 8'ha0);
    rd(`OFF_STATUS, 8'h00);
    $display("test reset_and_status done");
    wr(`OFF_CONTROL, 8'h93);
    settle();
    check("level", {7'h0, level}, 8'h00);
    rd(`OFF_STATUS, 8'h01);
    wr(`OFF_STATUS, 8'h01);
    rd(`OFF_STATUS, 8'h00);
    wr(`OFF_CONTROL, 8'h82);
    settle();
    rd(`OFF_STATUS, 8'h01);
    wr(`OFF_STATUS, 8'h01);
    above <= 1'b0;
    settle();
    rd(`OFF_STATUS, 8'h00);
    above <= 1'b1;
    settle();
    rd(`OFF_STATUS, 8'h01);
    $display("test edges done");
    wr(`OFF_MASK, 8'h01);
    wr(`OFF_PERIPH, 8'h03);
    settle();
    check("irq", {7'h0, irq}, 8'h01);
    wr(`OFF_MASK, 8'h00);
    settle();
    check("irq", {7'h0, irq}, 8'h00);
    wr(`OFF_MASK, 8'h01);
    wr(`OFF_STATUS, 8'h01);
    settle();
    check("irq", {7'h0, irq}, 8'h00);
    wr(`OFF_CONTROL, 8'h00);
    settle();
    check("pin_override", {7'h0, pin_ovr}, 8'h00);
    rd(`OFF_CONTROL, 8'h20);
    $display("test interrupt done");
    repeat (6)
    begin
      seed = xs(seed);
      above <= seed[8];
      wr(`OFF_CONTROL, seed[7:0] & `CTL_WR_MASK);
      settle();
      rd(`OFF_CONTROL, (seed[7:0] & `CTL_WR_MASK)
         | {2'b0, seed[8] ^ seed[4], 5'h0});
      wr(`OFF_STATUS, 8'h01);
    end
    $display("test random_control done");
    end_sim();
  end
endmodule : tb
